// >>> shared/tsct_regs.svh
`ifndef TSCT_REGS_SVH
`define TSCT_REGS_SVH
// Base cycle counts at zero wait-states
`define TSCT_CYC_ONE 4'h1
`define TSCT_CYC_TWO 4'h2
`define TSCT_CYC_THREE 4'h3
// Default cost of supervisor call and breakpoint
`define TSCT_CYC_TRAP_DEF 4'h4
// Address window of the single-cycle I/O port (top nibble)
`define TSCT_IOPORT_NIB 4'hD
// System control space window (top nibble)
`define TSCT_SCS_NIB 4'hE
`endif

// >>> shared/tsct_pkg.sv
`default_nettype none
package tsct_pkg;
    // Instruction classes produced by the decoder
    typedef enum logic [4:0] {
        TSCT_C_ALU = 5'h00,
        TSCT_C_ALU_PC = 5'h01,
        TSCT_C_LDST = 5'h02,
        TSCT_C_MULTI = 5'h03,
        TSCT_C_POP_PC = 5'h04,
        TSCT_C_BCOND = 5'h05,
        TSCT_C_BRANCH = 5'h06,
        TSCT_C_BL = 5'h07,
        TSCT_C_BARRIER = 5'h08,
        TSCT_C_SPECREG = 5'h09,
        TSCT_C_TRAP = 5'h0A,
        TSCT_C_WFE = 5'h0B,
        TSCT_C_WFI = 5'h0C,
        TSCT_C_UNDEF = 5'h0D
    } tsct_class_t;
    typedef enum logic [2:0] {
        TSCT_S_IDLE = 3'b001,
        TSCT_S_BUSY = 3'b010,
        TSCT_S_SLEEP = 3'b100
    } tsct_state_t;
endpackage : tsct_pkg
`default_nettype wire

// >>> hw/tsct_decode.sv
`timescale 1ns/1ps
`default_nettype none
// Classifies one instruction and gives its list length
module tsct_decode (
    input wire logic [15:0] hw0, // First halfword
    input wire logic [15:0] hw1, // Second halfword
    output tsct_pkg::tsct_class_t cls, // Instruction class
    output logic wide, // Uses two halfwords
    output logic [4:0] list_n // Elements in register list
);
    // Count set bits of a register list
    function automatic logic [4:0] popc(input logic [8:0] v);
        logic [4:0] s;
        s = 5'h00;
        for (int i = 0; i < 9; i++) begin
            s = s + {4'h0, v[i]};
        end
        return s;
    endfunction : popc

    // Decode by opcode fields
    always_comb begin
        cls = tsct_pkg::TSCT_C_UNDEF;
        wide = 1'b0;
        list_n = 5'h00;
        if (hw0[15:11] == 5'b11110 || hw0[15:11] == 5'b11111 || hw0[15:11] == 5'b11101) begin
            wide = 1'b1;
            if (hw0[15:11] == 5'b11110 && hw1[15:14] == 2'b11 && hw1[12] == 1'b1)
                cls = tsct_pkg::TSCT_C_BL;
            else if (hw0[15:4] == 12'hF3B && hw1[15:8] == 8'h8F && hw1[7:6] == 2'b01)
                cls = (hw1[5:4] == 2'b11) ? tsct_pkg::TSCT_C_UNDEF : tsct_pkg::TSCT_C_BARRIER;
            else if ((hw0[15:4] == 12'hF3E && hw1[15:12] == 4'h8)
                || (hw0[15:4] == 12'hF38 && hw1[15:8] == 8'h88))
                cls = tsct_pkg::TSCT_C_SPECREG;
        end else if (hw0[15:14] == 2'b00) begin
            cls = tsct_pkg::TSCT_C_ALU; // Shifts, add, sub, move, compare immediate
        end else if (hw0[15:10] == 6'b010000) begin
            cls = tsct_pkg::TSCT_C_ALU; // Register data processing and multiply
        end else if (hw0[15:10] == 6'b010001) begin
            if (hw0[9:8] == 2'b11)
                cls = tsct_pkg::TSCT_C_BRANCH; // Branch exchange forms
            else if (hw0[9:8] != 2'b01 && {hw0[7], hw0[2:0]} == 4'hF)
                cls = tsct_pkg::TSCT_C_ALU_PC;
            else
                cls = tsct_pkg::TSCT_C_ALU;
        end else if (hw0[15:11] == 5'b01001 || hw0[15:12] == 4'b0101 || hw0[15:13] == 3'b011
            || hw0[15:12] == 4'b1000 || hw0[15:12] == 4'b1001) begin
            cls = tsct_pkg::TSCT_C_LDST;
        end else if (hw0[15:12] == 4'b1010 || hw0[15:8] == 8'hB0) begin
            cls = tsct_pkg::TSCT_C_ALU; // Address forming and stack adjust
        end else if (hw0[15:12] == 4'b1100) begin
            cls = tsct_pkg::TSCT_C_MULTI;
            list_n = popc({1'b0, hw0[7:0]});
        end else if (hw0[15:12] == 4'b1011) begin
            if (hw0[11:9] == 3'b010 || hw0[11:9] == 3'b110) begin
                list_n = popc(hw0[8:0]);
                cls = (hw0[11] && hw0[8]) ? tsct_pkg::TSCT_C_POP_PC : tsct_pkg::TSCT_C_MULTI;
            end else if (hw0[11:8] == 4'h2 || hw0[11:8] == 4'hA) begin
                cls = (hw0[11:6] == 6'h2A) ? tsct_pkg::TSCT_C_UNDEF : tsct_pkg::TSCT_C_ALU;
            end else if (hw0[11:5] == 7'b0110011 && hw0[3:0] == 4'h2) begin
                cls = tsct_pkg::TSCT_C_ALU; // Interrupt mask set or clear
            end else if (hw0[11:8] == 4'hE) begin
                cls = tsct_pkg::TSCT_C_TRAP;
            end else if (hw0[11:8] == 4'hF && hw0[3:0] == 4'h0) begin
                case (hw0[7:4])
                    4'h2: cls = tsct_pkg::TSCT_C_WFE;
                    4'h3: cls = tsct_pkg::TSCT_C_WFI;
                    default: cls = tsct_pkg::TSCT_C_ALU; // Yield, send event, no-op
                endcase
            end
        end else if (hw0[15:12] == 4'b1101) begin
            if (hw0[11:8] == 4'hF) cls = tsct_pkg::TSCT_C_TRAP;
            else if (hw0[11:8] != 4'hE) cls = tsct_pkg::TSCT_C_BCOND;
        end else if (hw0[15:11] == 5'b11100) begin
            cls = tsct_pkg::TSCT_C_BRANCH;
        end
    end
endmodule : tsct_decode
`default_nettype wire

// >>> hw/tsct_core.sv
`timescale 1ns/1ps
`default_nettype none
`include "tsct_regs.svh"
// Functional notes
// - Accept all legacy compact instructions except compare-branch-zero/nonzero and if-then.
// - Wide forms: branch-with-link, three barriers, special-register moves; each 3 cycles.
// - Counts assume zero wait-states; bus wait-states add on top.
// - Moves, arithmetic, logic, compare, multiply: 1 cycle; PC destination 2.
// - All shifts and rotate by register take 1 cycle.
// - Extends, reverses, interrupt mask, send-event, no-op: 1 cycle.
// - Single load/store: 2 cycles on system bus or control space, 1 on I/O port.
// - Load/store multiple and plain push/pop: 1 plus N cycles.
// - Push with link 1+N, pop with return 3+N, N including LR or PC.
// - Conditional branch: 2 cycles taken, 1 not taken.
// - Unconditional branch, branch-exchange, branch-link-exchange: 2 cycles.
// - Supervisor call and breakpoint cost set by configuration.
// - Wait-event and wait-interrupt 2 cycles, yield 1, excluding suspension.
// - Wait-event clears a set event flag at once, else may suspend until wakeup.
module tsct_core #(
    parameter logic [3:0] TRAP_CYCLES = `TSCT_CYC_TRAP_DEF // Configured trap cost
) (
    input wire logic core_clk, // Processor clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic issue, // Instruction presented
    input wire logic [15:0] instr_hw0, // First halfword
    input wire logic [15:0] instr_hw1, // Second halfword, wide forms
    input wire logic [31:0] mem_addr, // Load/store target address
    input wire logic branch_taken, // Condition passed for conditional branch
    input wire logic bus_wait, // Bus inserts a wait-state this cycle
    input wire logic wake_event, // Wakeup event pulse, same clock
    input wire logic wake_irq, // Interrupt wakeup, same clock
    output logic ready, // Core can take an instruction
    output logic retire, // Instruction completes this cycle
    output logic wide_instr, // Last issued instruction was 32-bit
    output logic [5:0] cycle_count, // Cycles taken by last instruction
    output logic undef_fault, // Undefined encoding fault pulse
    output logic sleeping, // Suspended in wait hint
    output logic event_flag // Event register
);
    tsct_pkg::tsct_class_t cls;
    logic wide;
    logic [4:0] list_n;
    tsct_pkg::tsct_state_t state, next_state;
    logic [5:0] remain, next_remain;
    logic [5:0] used, next_used;
    logic next_wide_instr;
    logic [5:0] next_cycle_count;
    logic next_undef_fault;
    logic next_event_flag;
    logic [5:0] base;
    logic io_target;
    logic pend_sleep, next_pend_sleep;

    tsct_decode u_dec (
        .hw0(instr_hw0),
        .hw1(instr_hw1),
        .cls(cls),
        .wide(wide),
        .list_n(list_n)
    );

    // Single-cycle I/O port is selected by the address window
    assign io_target = (mem_addr[31:28] == `TSCT_IOPORT_NIB);

    // Base cost per class
    always_comb begin
        base = {2'h0, `TSCT_CYC_ONE};
        case (cls)
            tsct_pkg::TSCT_C_ALU: base = {2'h0, `TSCT_CYC_ONE};
            tsct_pkg::TSCT_C_ALU_PC: base = {2'h0, `TSCT_CYC_TWO};
            tsct_pkg::TSCT_C_LDST: base = io_target ? {2'h0, `TSCT_CYC_ONE} : {2'h0, `TSCT_CYC_TWO};
            tsct_pkg::TSCT_C_MULTI: base = {2'h0, `TSCT_CYC_ONE} + {1'b0, list_n};
            tsct_pkg::TSCT_C_POP_PC: base = {2'h0, `TSCT_CYC_THREE} + {1'b0, list_n};
            tsct_pkg::TSCT_C_BCOND: base = branch_taken ? {2'h0, `TSCT_CYC_TWO} : {2'h0, `TSCT_CYC_ONE};
            tsct_pkg::TSCT_C_BRANCH: base = {2'h0, `TSCT_CYC_TWO};
            tsct_pkg::TSCT_C_BL, tsct_pkg::TSCT_C_BARRIER,
            tsct_pkg::TSCT_C_SPECREG: base = {2'h0, `TSCT_CYC_THREE};
            tsct_pkg::TSCT_C_TRAP: base = {2'h0, TRAP_CYCLES};
            tsct_pkg::TSCT_C_WFE, tsct_pkg::TSCT_C_WFI: base = {2'h0, `TSCT_CYC_TWO};
            default: base = {2'h0, `TSCT_CYC_ONE};
        endcase
    end

    // Handshake outputs
    assign ready = (state == tsct_pkg::TSCT_S_IDLE);
    assign sleeping = (state == tsct_pkg::TSCT_S_SLEEP);

    // Sequencer: counts down the base cost, stretched by wait-states
    always_comb begin
        next_state = state;
        next_remain = remain;
        next_used = used;
        next_wide_instr = wide_instr;
        next_cycle_count = cycle_count;
        next_undef_fault = 1'b0;
        next_event_flag = event_flag | wake_event; // Set wins over clear below
        retire = 1'b0;
        case (state)
            tsct_pkg::TSCT_S_IDLE: begin
                if (issue) begin
                    next_wide_instr = wide;
                    next_used = 6'h01;
                    if (cls == tsct_pkg::TSCT_C_UNDEF) begin
                        next_undef_fault = 1'b1;
                        next_cycle_count = 6'h01;
                    end else if (base == 6'h01 && !(cls == tsct_pkg::TSCT_C_LDST && bus_wait)) begin
                        retire = 1'b1;
                        next_cycle_count = 6'h01;
                    end else begin
                        next_state = tsct_pkg::TSCT_S_BUSY;
                        next_remain = (cls == tsct_pkg::TSCT_C_LDST && bus_wait) ? base : base - 6'h01;
                    end
                    if (cls == tsct_pkg::TSCT_C_WFE)
                        next_event_flag = wake_event;
                end
            end
            tsct_pkg::TSCT_S_BUSY: begin
                next_used = used + 6'h01;
                if (bus_wait) begin
                    next_remain = remain;
                end else if (remain == 6'h01) begin
                    next_cycle_count = used + 6'h01;
                    if (pend_sleep && !wake_irq && !wake_event) begin
                        next_state = tsct_pkg::TSCT_S_SLEEP; // Base cycles done, completes on wakeup
                    end else begin
                        retire = 1'b1;
                        next_state = tsct_pkg::TSCT_S_IDLE;
                    end
                end else if (remain == 6'h02 && used == 6'h01 && next_remain == remain) begin
                    next_remain = 6'h01;
                end else begin
                    next_remain = remain - 6'h01;
                end
            end
            tsct_pkg::TSCT_S_SLEEP: begin
                if (wake_event || wake_irq) begin
                    retire = 1'b1; // suspension not counted
                    next_state = tsct_pkg::TSCT_S_IDLE; // Flag keeps a same-cycle wakeup event
                end
            end
            default: next_state = tsct_pkg::TSCT_S_IDLE;
        endcase
    end

    // Wait hints that must suspend enter sleep after their base cycles
    always_comb begin
        next_pend_sleep = pend_sleep;
        if (state == tsct_pkg::TSCT_S_IDLE && issue)
            next_pend_sleep = (cls == tsct_pkg::TSCT_C_WFI)
                || (cls == tsct_pkg::TSCT_C_WFE && !event_flag && !wake_event);
        else if (retire)
            next_pend_sleep = 1'b0;
    end

    // State registers
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            state <= tsct_pkg::TSCT_S_IDLE;
            remain <= 6'h00;
            used <= 6'h00;
            wide_instr <= 1'b0;
            cycle_count <= 6'h00;
            undef_fault <= 1'b0;
            event_flag <= 1'b0;
            pend_sleep <= 1'b0;
        end else begin
            state <= next_state;
            remain <= next_remain;
            used <= next_used;
            wide_instr <= next_wide_instr;
            cycle_count <= next_cycle_count;
            undef_fault <= next_undef_fault;
            event_flag <= next_event_flag;
            pend_sleep <= next_pend_sleep;
        end
    end
endmodule : tsct_core
`default_nettype wire

// >>> test/tsct_props.sv
`timescale 1ns/1ps
`default_nettype none
// Port timing checks on the cycle-timing core
module tsct_props (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic issue, // Offer
    input wire logic [15:0] instr_hw0, // First half
    input wire logic [31:0] mem_addr, // Target
    input wire logic branch_taken, // Condition
    input wire logic bus_wait, // Wait-state
    input wire logic wake_event, // Event in
    input wire logic ready, // Idle
    input wire logic retire, // Done
    input wire logic undef_fault, // Fault
    input wire logic event_flag // Event register
);
    wire logic go = issue && ready; // Taken this edge
    wire logic [7:0] op = instr_hw0[15:8]; // Top byte
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // Short classes retire in the issue cycle, a move to the PC or a taken conditional branch does not
    mul_one_a: assert property (go && instr_hw0[15:6] == 10'h10D |-> retire)
        else $error("multiply late");
    pc_dest_a: assert property (go && op == 8'h46 && instr_hw0[7] && instr_hw0[2:0] == 3'h7 |-> !retire)
        else $error("pc move early");
    extend_one_a: assert property (go && (op == 8'hB2 || (op == 8'hBA && instr_hw0[7:6] != 2'h2)) |-> retire)
        else $error("extend late");
    io_port_a: assert property (go && instr_hw0[15:11] == 5'h0D && mem_addr[31:28] == 4'hD |-> retire)
        else $error("io access late");
    bcond_a: assert property (go && op[7:4] == 4'hD && op[3:1] != 3'h7 |-> retire == !branch_taken)
        else $error("branch count");
    // Wide forms finish on the third cycle when no wait-state comes
    wide_three_a: assert property (
        go && instr_hw0[15:11] == 5'h1E ##1 !undef_fault && !bus_wait ##1 !bus_wait |-> retire && !$past(retire))
        else $error("wide count");
    cbz_undef_a: assert property (go && op inside {8'hB1, 8'hB3, 8'hB9, 8'hBB} |-> !retire ##1 undef_fault)
        else $error("compare branch taken in");
    event_clr_a: assert property (go && instr_hw0 == 16'hBF20 && !wake_event ##1 !wake_event |=> !event_flag)
        else $error("event kept");
endmodule : tsct_props
`default_nettype wire

// >>> test/tsct_bus_model.sv
`timescale 1ns/1ps
`default_nettype none
// Interconnect stand-in: a set number of wait-states per access
module tsct_bus_model (
    input wire logic core_clk, // Clock
    input wire logic rst_n, // Reset
    input wire logic ready, // Core idle
    input wire logic stall_load, // Take a new budget
    input wire logic [3:0] stall_len, // Wait-states wanted
    output logic bus_wait // Wait-state now
);
    logic [3:0] budget;
    logic [3:0] next_budget;
    // Stall only while an access is in flight
    always_comb begin
        bus_wait = !ready && budget != 4'h0;
        next_budget = stall_load ? stall_len : budget - {3'h0, bus_wait};
    end
    // Budget register
    always_ff @(posedge core_clk) begin
        if (!rst_n) begin
            budget <= 4'h0;
        end else begin
            budget <= next_budget;
        end
    end
endmodule : tsct_bus_model
`default_nettype wire

// >>> test/tb.sv
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin checked++; if ((g) !== (e)) begin errors++; $display("Error %0t %0h %0h", $time, g, e); end end
module tb;
    localparam logic [3:0] TRAP = 4'h5; // Non-default trap cost
    logic core_clk = 1'b0, rst_n = 1'b0, issue = 1'b0, branch_taken = 1'b0, wake_event = 1'b0, wake_irq = 1'b0;
    logic stall_load = 1'b0, slept = 1'b0, bus_wait, ready, retire, wide_instr, undef_fault, sleeping, event_flag;
    logic [15:0] hw0 = 16'h0, hw1 = 16'h0;
    logic [31:0] mem_addr = 32'h0;
    logic [3:0] stall_len = 4'h0;
    logic [7:0] lfsr = 8'h06;
    logic [5:0] cycle_count;
    int errors = 0, checked = 0, cyc = 0;
    logic [31:0] tbl [$] = {32'h20050000, 32'h46870000, 32'h44870000, 32'h43480000, 32'h00880000, 32'h41C80000,
        32'hB2000000, 32'hBA400000, 32'hBAC00000, 32'hB6720000, 32'hBF400000, 32'hBF100000, 32'hBF000000,
        32'h5C080000, 32'h90000000, 32'hE0000000, 32'h47000000, 32'h47800000, 32'hD0010000, 32'hF000F800,
        32'hF3BF8F5F, 32'hF3BF8F4F, 32'hF3BF8F6F, 32'hF3EF8808, 32'hF3808808, 32'hDF000000, 32'hBE000000,
        32'hB1000000, 32'hB9000000, 32'hBF080000};
    logic [7:0] pfx [7] = '{8'hC8, 8'hC0, 8'hB4, 8'hB5, 8'hBC, 8'hBD, 8'h68};
    tsct_core #(.TRAP_CYCLES(TRAP)) i_tsct_core (.core_clk(core_clk), .rst_n(rst_n), .issue(issue), .instr_hw0(hw0),
        .instr_hw1(hw1), .mem_addr(mem_addr), .branch_taken(branch_taken), .bus_wait(bus_wait),
        .wake_event(wake_event), .wake_irq(wake_irq), .ready(ready), .retire(retire), .wide_instr(wide_instr),
        .cycle_count(cycle_count), .undef_fault(undef_fault), .sleeping(sleeping), .event_flag(event_flag));
    tsct_bus_model i_tsct_bus_model (.core_clk(core_clk), .rst_n(rst_n), .ready(ready), .stall_load(stall_load),
        .stall_len(stall_len), .bus_wait(bus_wait));
    // Clock and hang guard
    always #5 core_clk = ~core_clk;
    always @(posedge core_clk) begin
        cyc++;
        if (cyc == 6000) begin
            errors++;
            print_verdict();
        end
    end
    function automatic logic [7:0] next_rand(logic [7:0] v);
        return {v[6:0], v[7] ^ v[5] ^ v[4] ^ v[3]};
    endfunction : next_rand
    // Base cost at zero wait-states; 0 marks an undefined encoding
    function automatic int ref_cycles(logic [15:0] h, logic [31:0] a, logic t);
        int n = $countones(h[7:0]);
        if (h[15:8] inside {8'hB1, 8'hB3, 8'hB9, 8'hBB} || (h[15:8] == 8'hBF && h[3:0] != 4'h0)) return 0;
        if (h[15:11] == 5'h1E) return 3;
        if (h[15:8] inside {8'hDF, 8'hBE}) return TRAP;
        if (h[15:9] == 7'h5A) return 1 + n + h[8];
        if (h[15:9] == 7'h5E) return h[8] ? 4 + n : 1 + n;
        if (h[15:12] == 4'hC) return 1 + n;
        if (h[15:12] == 4'hD) return t ? 2 : 1;
        if (h[15:11] == 5'h1C || h[15:8] == 8'h47) return 2;
        if (h[15:12] inside {[4'h5:4'h9]} || h[15:11] == 5'h09) return a[31:28] == 4'hD ? 1 : 2;
        if (h == 16'hBF20 || h == 16'hBF30) return 2;
        return (h[15:10] == 6'h11 && !h[8] && h[7] && h[2:0] == 3'h7) ? 2 : 1;
    endfunction : ref_cycles
    // Offer one instruction, wake the core if it sleeps, measure and compare
    task automatic run(input logic [31:0] h, input logic [31:0] a, input logic t, input logic [3:0] st);
        int exp;
        int got;
        exp = ref_cycles(h[31:16], a, t);
        got = 0;
        slept = 1'b0;
        @(negedge core_clk);
        while (ready !== 1'b1 && got < 50) begin
            wake_irq = (sleeping === 1'b1);
            @(negedge core_clk);
            got++;
        end
        `CHK(ready, 1'b1)
        if (exp == 1) st = 4'h0;
        wake_irq = 1'b0;
        {hw0, hw1} = h;
        mem_addr = a;
        branch_taken = t;
        stall_len = st;
        stall_load = 1'b1;
        issue = 1'b1;
        got = 1;
        #1;
        if (exp == 0) begin
            @(negedge core_clk);
            `CHK(undef_fault, 1'b1)
            `CHK(retire, 1'b0)
        end else begin
            while (retire !== 1'b1 && got < 60) begin
                @(negedge core_clk);
                issue = 1'b0;
                stall_load = 1'b0;
                wake_irq = (sleeping === 1'b1);
                slept |= wake_irq;
                got++;
                #1;
            end
            `CHK(retire, 1'b1)
            @(negedge core_clk);
            if (!slept) `CHK(got, exp + st)
            `CHK(cycle_count, 6'(exp + st))
            `CHK(wide_instr, h[31:29] == 3'h7 && h[28:27] != 2'h0)
        end
        issue = 1'b0;
        stall_load = 1'b0;
        wake_irq = 1'b0;
    endtask : run
    task automatic print_verdict();
        $display("Comparisons %0d, mismatches %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask : print_verdict
    // Main sequence
    initial begin
        repeat (16) @(negedge core_clk);
        rst_n = 1'b1;
        foreach (tbl[i]) run(tbl[i], 32'h20000000, 1'b1, 4'h0);
        run(32'hD0010000, 32'h0, 1'b0, 4'h0);
        run(32'h68000000, 32'hD0000010, 1'b0, 4'h0);
        run(32'h5C080000, 32'hE000ED00, 1'b0, 4'h3);
        $display("Test fixed encodings done");
        for (int i = 0; i < 20; i++) begin
            lfsr = next_rand(lfsr);
            foreach (pfx[k]) run({pfx[k], lfsr, 16'h0}, {lfsr[3:0], 28'h100}, lfsr[0], {2'h0, lfsr[2:1]});
        end
        $display("Test random lists done");
        wake_event = 1'b1;
        @(negedge core_clk);
        wake_event = 1'b0;
        @(negedge core_clk);
        `CHK(event_flag, 1'b1)
        run(32'hBF200000, 32'h0, 1'b0, 4'h0);
        `CHK(event_flag, 1'b0)
        run(32'hBF200000, 32'h0, 1'b0, 4'h0);
        `CHK(slept | (sleeping === 1'b1), 1'b1)
        run(32'hBF300000, 32'h0, 1'b0, 4'h0);
        `CHK(slept | (sleeping === 1'b1), 1'b1)
        $display("Test wait hints done");
        print_verdict();
    end
endmodule : tb
bind tsct_core tsct_props i_tsct_props (.core_clk(core_clk), .rst_n(rst_n), .issue(issue), .instr_hw0(instr_hw0),
    .mem_addr(mem_addr), .branch_taken(branch_taken), .bus_wait(bus_wait), .wake_event(wake_event), .ready(ready),
    .retire(retire), .undef_fault(undef_fault), .event_flag(event_flag));
`default_nettype wire
